/* File: scan_map.svh */
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH

// Instruction register
`define IR_W 10
`define IR_CAPTURE 10'h001
`define IR_EXTEST 10'h000
`define IR_RECONFIG_PULSE 10'h001
`define IR_ICR_DATA 10'h002
`define IR_SAMPLE 10'h005
`define IR_IDCODE 10'h006
`define IR_USERCODE 10'h007
`define IR_CLAMP 10'h00A
`define IR_HIGHZ 10'h00B
`define IR_CONFIG_IO 10'h00D
`define IR_ANALYZER 10'h00E
`define IR_BYPASS 10'h3FF

// Data register sizes
`define WORD_W 32
`define N_PINS 8
`define CELLS_PER_PIN 3
`define BSR_LEN 24
`define PLL_LEN 8
`define CHAIN_LEN 32
`define IOSTD_PER_PIN 2
`define IOSTD_LEN 16

// Boundary cell positions within one pin
`define CELL_IN 0
`define CELL_OUT 1
`define CELL_OE 2

// Identification field positions
`define ID_VER_LSB 28
`define ID_PART_LSB 12
`define ID_MFR_LSB 1

// Reset values
`define IOSTD_RST 16'h0000
`define PLL_RST 8'h00
`define ANA_RST 32'h0000_0000

`endif

/* File: scan_pkg.sv */
package scan_pkg;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PA_DR = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA,
        TAP_SH_IR = 4'hB,
        TAP_EX1_IR = 4'hC,
        TAP_PA_IR = 4'hD,
        TAP_EX2_IR = 4'hE,
        TAP_UPD_IR = 4'hF
    } tap_state_e;

    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0,
        DR_WORD = 3'h1,
        DR_BSR = 3'h2,
        DR_IOSTD = 3'h3,
        DR_ICR = 3'h4
    } dr_sel_e;

    typedef enum logic [1:0] {
        PIN_NORMAL = 2'h0,
        PIN_BSR = 2'h1,
        PIN_HIGHZ = 2'h2
    } pin_mode_e;

endpackage

/* File: tap_if.sv */
interface tap_if;
    import scan_pkg::*;
    logic tck_rise;
    logic tms_bit;
    tap_state_e state;

    modport ctl
    (
        input tck_rise,
        input tms_bit,
        output state
    );

    modport user
    (
        output tck_rise,
        output tms_bit,
        input state
    );
endinterface

/* File: tap_fsm.sv */
module tap_fsm
    import scan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    tap_if.ctl tap
);

    tap_state_e state_r;
    tap_state_e state_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Sixteen-state sequencing, one step per test clock rising edge
    always_comb
    begin
        state_nxt = state_r;
        if (tap.tck_rise)
        begin
            unique case (state_r)
                TAP_RESET: state_nxt = tap.tms_bit ? TAP_RESET : TAP_IDLE;
                TAP_IDLE: state_nxt = tap.tms_bit ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: state_nxt = tap.tms_bit ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: state_nxt = tap.tms_bit ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR: state_nxt = tap.tms_bit ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: state_nxt = tap.tms_bit ? TAP_UPD_DR : TAP_PA_DR;
                TAP_PA_DR: state_nxt = tap.tms_bit ? TAP_EX2_DR : TAP_PA_DR;
                TAP_EX2_DR: state_nxt = tap.tms_bit ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: state_nxt = tap.tms_bit ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: state_nxt = tap.tms_bit ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: state_nxt = tap.tms_bit ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR: state_nxt = tap.tms_bit ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: state_nxt = tap.tms_bit ? TAP_UPD_IR : TAP_PA_IR;
                TAP_PA_IR: state_nxt = tap.tms_bit ? TAP_EX2_IR : TAP_PA_IR;
                TAP_EX2_IR: state_nxt = tap.tms_bit ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: state_nxt = tap.tms_bit ? TAP_SEL_DR : TAP_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= TAP_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign tap.state = state_r;

endmodule

/* File: boundary_scan_instruction_unit.sv */
`include "scan_map.svh"

// Function
// - Boundary scan test usable before and after configuration, never during it.
// - I/O-standard instruction rewrites every pin's electrical standard via the chain.
// - PLL reconfiguration bits join the chain only until configuration finishes.
// - Sample/preload captures pin signals and preloads a pattern for later driving.
// - Extest drives boundary pattern onto outputs and captures input pins.
// - Bypass puts a 1-bit register between serial input and output.
// - Usercode selects the 32-bit user code register for shifting out.
// - Idcode selects the identification register for shifting out.
// - Highz selects bypass and floats every I/O pin.
// - Clamp selects bypass and holds pins at boundary register levels.
// - Reconfiguration pulse instruction triggers reconfiguration without touching the pin.
// - I/O-standard instruction accepted anytime; aborts a running configuration.
// - After I/O-standard instruction, status held low until reconfiguration.
// - Checksum option loads the programming checksum as user code.
// - In-circuit reconfiguration instructions carry configuration data through the port.
// - Analyzer instruction gives the port access to internal monitoring.
// - Instruction register is 10 bits; codes shift in as 10 bits.
// - Identification: 4-bit version, 16-bit part, 11-bit maker, LSB one.
module boundary_scan_instruction_unit
    import scan_pkg::*;
#(
    // Arbitrary identification values
    parameter logic [3:0] ID_VERSION = 4'h1,
    parameter logic [15:0] ID_PART = 16'h1234,
    parameter logic [10:0] ID_MAKER = 11'h155
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic config_request_n,
    input wire logic config_busy,
    input wire logic config_done,
    input wire logic usercode_checksum_sel,
    input wire logic [`WORD_W-1:0] checksum,
    input wire logic [`WORD_W-1:0] user_code,
    input wire logic [`WORD_W-1:0] analyzer_probe,
    input wire logic [`N_PINS-1:0] pin_in,
    input wire logic [`N_PINS-1:0] core_out,
    input wire logic [`N_PINS-1:0] core_oe,
    output logic tdo,
    output logic tdo_oe,
    output logic [`N_PINS-1:0] pin_out,
    output logic [`N_PINS-1:0] pin_oe,
    output logic [`IOSTD_LEN-1:0] io_std,
    output logic [`PLL_LEN-1:0] pll_reconfig,
    output logic config_status_n,
    output logic config_abort,
    output logic reconfig_req,
    output logic icr_data,
    output logic icr_data_vld,
    output logic [`WORD_W-1:0] analyzer_ctrl
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for everything arriving from pins
    logic tck_s1_r, tck_s2_r, tck_d_r;
    logic tms_s1_r, tms_s2_r;
    logic tdi_s1_r, tdi_s2_r;
    logic req_s1_r, req_s2_r;
    logic [`N_PINS-1:0] pin_s1_r, pin_s2_r;
    logic tck_rise, tck_fall;

    // Only the second stage and the delayed test clock copy feed logic; the first is never looked at
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tck_s1_r <= 1'h0;
            tck_s2_r <= 1'h0;
            tck_d_r <= 1'h0;
            tms_s1_r <= 1'h1;
            tms_s2_r <= 1'h1;
            tdi_s1_r <= 1'h1;
            tdi_s2_r <= 1'h1;
            req_s1_r <= 1'h1;
            req_s2_r <= 1'h1;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end
        else
        begin
            tck_s1_r <= tck;
            tck_s2_r <= tck_s1_r;
            tck_d_r <= tck_s2_r;
            tms_s1_r <= tms;
            tms_s2_r <= tms_s1_r;
            tdi_s1_r <= tdi;
            tdi_s2_r <= tdi_s1_r;
            req_s1_r <= config_request_n;
            req_s2_r <= req_s1_r;
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Edges found on the sampled test clock
    assign tck_rise = tck_s2_r & ~tck_d_r;
    assign tck_fall = ~tck_s2_r & tck_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Controller
    tap_if tap();

    assign tap.tck_rise = tck_rise;
    assign tap.tms_bit = tms_s2_r;

    tap_fsm u_tap_fsm
    (
        .clk(clk),
        .rst_b(rst_b),
        .tap(tap.ctl)
    );

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [`IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
    logic byp_r, byp_nxt;
    logic [`WORD_W-1:0] word_r, word_nxt;
    logic [`CHAIN_LEN-1:0] chain_r, chain_nxt;
    logic [`BSR_LEN-1:0] bsr_upd_r, bsr_upd_nxt, bsr_cap;
    logic [`PLL_LEN-1:0] pll_r, pll_nxt;
    logic [`IOSTD_LEN-1:0] iostd_sh_r, iostd_sh_nxt, iostd_r, iostd_nxt;
    logic [`WORD_W-1:0] ana_r, ana_nxt;
    logic status_n_r, status_n_nxt;
    logic abort_r, abort_nxt;
    logic reconf_r, reconf_nxt;
    logic icr_r, icr_nxt, icr_vld_r, icr_vld_nxt;
    logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
    logic [`N_PINS-1:0] pin_out_r, pin_oe_r, pin_out_nxt, pin_oe_nxt;
    logic [`WORD_W-1:0] id_word;
    logic pll_in_chain, in_shift, sel_bit;
    dr_sel_e dr_sel;
    pin_mode_e pin_mode;

    // Identification word with its fixed one in the bottom bit
    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'h1};

    // PLL bits stay in the chain only until configuration is done
    assign pll_in_chain = ~config_done;

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode; pin-driving tests are held off while configuring
    always_comb
    begin
        dr_sel = DR_BYPASS;
        pin_mode = PIN_NORMAL;
        case (ir_r)
            `IR_EXTEST:
            begin
                if (!config_busy)
                begin
                    dr_sel = DR_BSR;
                    pin_mode = PIN_BSR;
                end
            end
            `IR_SAMPLE:
            begin
                if (!config_busy)
                begin
                    dr_sel = DR_BSR;
                end
            end
            `IR_HIGHZ:
            begin
                if (!config_busy)
                begin
                    pin_mode = PIN_HIGHZ;
                end
            end
            `IR_CLAMP:
            begin
                if (!config_busy)
                begin
                    pin_mode = PIN_BSR;
                end
            end
            `IR_IDCODE: dr_sel = DR_WORD;
            `IR_USERCODE: dr_sel = DR_WORD;
            `IR_ANALYZER: dr_sel = DR_WORD;
            `IR_CONFIG_IO: dr_sel = DR_IOSTD;
            `IR_ICR_DATA: dr_sel = DR_ICR;
            default: dr_sel = DR_BYPASS;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin capture cells and output steering
    genvar gi;
    generate
        for (gi = 0; gi < `N_PINS; gi++)
        begin : g_pin
            // Pins and core drive are captured; same cells used by sample and extest
            assign bsr_cap[gi*`CELLS_PER_PIN+`CELL_IN] = pin_s2_r[gi];
            assign bsr_cap[gi*`CELLS_PER_PIN+`CELL_OUT] = core_out[gi];
            assign bsr_cap[gi*`CELLS_PER_PIN+`CELL_OE] = core_oe[gi];

            // Extest and clamp both drive from the update latches
            always_comb
            begin
                pin_out_nxt[gi] = core_out[gi];
                pin_oe_nxt[gi] = core_oe[gi];
                unique case (pin_mode)
                    PIN_NORMAL:
                    begin
                        pin_out_nxt[gi] = core_out[gi];
                        pin_oe_nxt[gi] = core_oe[gi];
                    end
                    PIN_BSR:
                    begin
                        pin_out_nxt[gi] = bsr_upd_r[gi*`CELLS_PER_PIN+`CELL_OUT];
                        pin_oe_nxt[gi] = bsr_upd_r[gi*`CELLS_PER_PIN+`CELL_OE];
                    end
                    PIN_HIGHZ:
                    begin
                        pin_out_nxt[gi] = 1'h0;
                        pin_oe_nxt[gi] = 1'h0;
                    end
                    default:
                    begin
                        pin_out_nxt[gi] = core_out[gi];
                        pin_oe_nxt[gi] = core_oe[gi];
                    end
                endcase
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Serial bit presented for the falling edge
    always_comb
    begin
        unique case (dr_sel)
            DR_WORD: sel_bit = word_r[0];
            DR_BSR: sel_bit = chain_r[0];
            DR_IOSTD: sel_bit = iostd_sh_r[0];
            DR_ICR: sel_bit = icr_r;
            default: sel_bit = byp_r;
        endcase
        if (tap.state == TAP_SH_IR)
        begin
            sel_bit = ir_sh_r[0];
        end
    end

    assign in_shift = (tap.state == TAP_SH_DR) || (tap.state == TAP_SH_IR);

    ////////////////////////////////////////////////////////////////////////
    // Capture, shift and update of every scan register
    always_comb
    begin
        ir_nxt = ir_r;
        ir_sh_nxt = ir_sh_r;
        byp_nxt = byp_r;
        word_nxt = word_r;
        chain_nxt = chain_r;
        bsr_upd_nxt = bsr_upd_r;
        pll_nxt = pll_r;
        iostd_sh_nxt = iostd_sh_r;
        iostd_nxt = iostd_r;
        ana_nxt = ana_r;
        abort_nxt = 1'h0;
        reconf_nxt = 1'h0;
        icr_nxt = icr_r;
        icr_vld_nxt = 1'h0;
        tdo_nxt = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        status_n_nxt = status_n_r;
        // Reconfiguration, by instruction or by the pin, releases the status hold
        if (reconf_r || !req_s2_r)
        begin
            status_n_nxt = 1'h1;
        end
        if (tap.state == TAP_RESET)
        begin
            ir_nxt = `IR_IDCODE;
        end
        if (tck_rise)
        begin
            unique case (tap.state)
                TAP_CAP_IR: ir_sh_nxt = `IR_CAPTURE;
                TAP_SH_IR: ir_sh_nxt = {tdi_s2_r, ir_sh_r[`IR_W-1:1]};
                TAP_CAP_DR:
                begin
                    byp_nxt = 1'h0;
                    chain_nxt = {pll_r, bsr_cap};
                    iostd_sh_nxt = iostd_r;
                    if (ir_r == `IR_IDCODE)
                    begin
                        word_nxt = id_word;
                    end
                    else if (ir_r == `IR_ANALYZER)
                    begin
                        word_nxt = analyzer_probe;
                    end
                    else
                    begin
                        word_nxt = usercode_checksum_sel ? checksum : user_code;
                    end
                end
                TAP_SH_DR:
                begin
                    byp_nxt = tdi_s2_r;
                    word_nxt = {tdi_s2_r, word_r[`WORD_W-1:1]};
                    iostd_sh_nxt = {tdi_s2_r, iostd_sh_r[`IOSTD_LEN-1:1]};
                    if (dr_sel == DR_BSR)
                    begin
                        // With PLL bits out, serial data enters below them
                        if (pll_in_chain)
                        begin
                            chain_nxt = {tdi_s2_r, chain_r[`CHAIN_LEN-1:1]};
                        end
                        else
                        begin
                            chain_nxt[`BSR_LEN-1:0] = {tdi_s2_r, chain_r[`BSR_LEN-1:1]};
                        end
                    end
                    if (dr_sel == DR_ICR)
                    begin
                        icr_nxt = tdi_s2_r;
                        icr_vld_nxt = 1'h1;
                    end
                end
                default:
                begin
                    ir_sh_nxt = ir_sh_r;
                end
            endcase
        end
        if (tck_fall)
        begin
            tdo_nxt = sel_bit;
            tdo_oe_nxt = in_shift;
            if (tap.state == TAP_UPD_IR)
            begin
                ir_nxt = ir_sh_r;
                if (ir_sh_r == `IR_CONFIG_IO)
                begin
                    status_n_nxt = 1'h0;
                    abort_nxt = config_busy;
                end
                if (ir_sh_r == `IR_RECONFIG_PULSE)
                begin
                    reconf_nxt = 1'h1;
                end
            end
            if (tap.state == TAP_UPD_DR)
            begin
                unique case (dr_sel)
                    DR_BSR:
                    begin
                        bsr_upd_nxt = chain_r[`BSR_LEN-1:0];
                        if (pll_in_chain)
                        begin
                            pll_nxt = chain_r[`CHAIN_LEN-1:`BSR_LEN];
                        end
                    end
                    DR_IOSTD: iostd_nxt = iostd_sh_r;
                    DR_WORD:
                    begin
                        if (ir_r == `IR_ANALYZER)
                        begin
                            ana_nxt = word_r;
                        end
                    end
                    default: bsr_upd_nxt = bsr_upd_r;
                endcase
            end
        end
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ir_r <= `IR_IDCODE;
            ir_sh_r <= `IR_CAPTURE;
            byp_r <= 1'h0;
            word_r <= '0;
            chain_r <= '0;
            bsr_upd_r <= '0;
            pll_r <= `PLL_RST;
            iostd_sh_r <= `IOSTD_RST;
            iostd_r <= `IOSTD_RST;
            ana_r <= `ANA_RST;
            status_n_r <= 1'h1;
            abort_r <= 1'h0;
            reconf_r <= 1'h0;
            icr_r <= 1'h0;
            icr_vld_r <= 1'h0;
            tdo_r <= 1'h0;
            tdo_oe_r <= 1'h0;
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end
        else
        begin
            ir_r <= ir_nxt;
            ir_sh_r <= ir_sh_nxt;
            byp_r <= byp_nxt;
            word_r <= word_nxt;
            chain_r <= chain_nxt;
            bsr_upd_r <= bsr_upd_nxt;
            pll_r <= pll_nxt;
            iostd_sh_r <= iostd_sh_nxt;
            iostd_r <= iostd_nxt;
            ana_r <= ana_nxt;
            status_n_r <= status_n_nxt;
            abort_r <= abort_nxt;
            reconf_r <= reconf_nxt;
            icr_r <= icr_nxt;
            icr_vld_r <= icr_vld_nxt;
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    assign tdo = tdo_r;
    assign tdo_oe = tdo_oe_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign io_std = iostd_r;
    assign pll_reconfig = pll_r;
    assign config_status_n = status_n_r;
    assign config_abort = abort_r;
    assign reconfig_req = reconf_r;
    assign icr_data = icr_r;
    assign icr_data_vld = icr_vld_r;
    assign analyzer_ctrl = ana_r;

endmodule

/* File: scan_unit_checker.sv */
`include "scan_map.svh"

module scan_unit_checker
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic config_request_n,
    input wire logic config_done,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [`IOSTD_LEN-1:0] io_std,
    input wire logic [`PLL_LEN-1:0] pll_reconfig,
    input wire logic config_status_n,
    input wire logic config_abort,
    input wire logic reconfig_req,
    input wire logic icr_data_vld
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////
    // Status release: request pulse first, clear one clock later
    sequence req_then_clear;
        reconfig_req ##1 (!reconfig_req && config_status_n);
    endsequence

    ////////////////////////////////////////
    rest_vals_a: assert property ($rose(rst_b) |-> config_status_n && !tdo_oe && !tdo && !reconfig_req)
        else $error("outputs not at rest after reset");
    tdo_edge_a: assert property (($changed(tdo) || $changed(tdo_oe)) |-> !tck && !$past(tck))
        else $error("serial output moved outside low test clock");
    iostd_upd_a: assert property ($changed(io_std) |-> !tck)
        else $error("io standard moved outside update");
    pll_keep_a: assert property (config_done && $past(config_done) |-> $stable(pll_reconfig))
        else $error("pll bits changed after configuration");
    abort_pulse_a: assert property (config_abort |-> !config_status_n ##1 !config_abort)
        else $error("abort without status low or too long");
    icr_pulse_a: assert property (icr_data_vld |=> !icr_data_vld [*4])
        else $error("incircuit data strobe too long");
    status_clear_a: assert property (reconfig_req |-> req_then_clear)
        else $error("status not released after reconfig pulse");
    status_hold_a: assert property ($rose(config_status_n) |-> $past(reconfig_req) || !$past(config_request_n, 3))
        else $error("status released without reconfiguration");
endmodule

bind boundary_scan_instruction_unit scan_unit_checker u_scan_unit_checker
(
    .clk(clk), .rst_b(rst_b), .tck(tck), .config_request_n(config_request_n), .config_done(config_done),
    .tdo(tdo), .tdo_oe(tdo_oe), .io_std(io_std), .pll_reconfig(pll_reconfig),
    .config_status_n(config_status_n), .config_abort(config_abort), .reconfig_req(reconfig_req),
    .icr_data_vld(icr_data_vld)
);

/* File: scan_tester.sv */
module scan_tester
(
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    // Test clock rests low between frames
    initial
    begin
        tck = 0;
        tms = 1;
        tdi = 0;
    end

    ////////////////////////////////////////
    // One 160 ns tester cycle; output read just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #70 q = tdo_oe ? tdo : 1'bx;
        #10 tck = 1;
        #80 tck = 0;
    endtask

    // Five ones reach reset from any state, then park in idle
    task automatic tlr();
        logic q;
        repeat (5) step(1, ~tdi, q);
        step(0, ~tdi, q);
    endtask

    // Idle to shift, n bits LSB first, through update back to idle
    task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1, ~tdi, q);
        if (ir)
            step(1, ~tdi, q);
        step(0, ~tdi, q);
        step(0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1, ~tdi, q);
        step(0, ~tdi, q);
    endtask
endmodule

/* File: boundary_scan_instruction_unit_bench.sv */
`include "scan_map.svh"

module boundary_scan_instruction_unit_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // Arbitrary identification values
    localparam logic [3:0] ID_V = 4'h3;
    localparam logic [15:0] ID_P = 16'hBEEF;
    localparam logic [10:0] ID_M = 11'h2AB;
    logic clk = 0;
    logic rst_b = 0;
    logic tck, tms, tdi, tdo, tdo_oe, config_status_n, config_abort, reconfig_req, icr_data, icr_data_vld;
    logic config_request_n = 1;
    logic config_busy = 0;
    logic config_done = 0;
    logic usercode_checksum_sel = 0;
    logic [31:0] checksum, user_code, analyzer_probe, analyzer_ctrl, d, q, exp;
    logic [7:0] pin_in, core_out, core_oe, pin_out, pin_oe, pll_reconfig, bo, be;
    logic [7:0] pll_m = 8'h00;
    logic [15:0] io_std;
    logic [23:0] bsr_m;
    logic [9:0] codes [8] = '{10'h006, 10'h007, 10'h007, 10'h00E, 10'h3FF, 10'h00B, 10'h00A, 10'h3A5};
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'hf32b;
    int aborts, reqs, vlds;

    always #5 clk = ~clk;
    // Pulse counters; each pulse is seen at exactly one edge
    always @(posedge clk)
    begin
        aborts += config_abort;
        reqs += reconfig_req;
        vlds += icr_data_vld;
    end

    scan_tester u_scan_tester(.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    boundary_scan_instruction_unit #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M))
        u_boundary_scan_instruction_unit
    (
        .clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .config_request_n(config_request_n),
        .config_busy(config_busy), .config_done(config_done), .usercode_checksum_sel(usercode_checksum_sel),
        .checksum(checksum), .user_code(user_code), .analyzer_probe(analyzer_probe), .pin_in(pin_in),
        .core_out(core_out), .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .pin_out(pin_out), .pin_oe(pin_oe),
        .io_std(io_std), .pll_reconfig(pll_reconfig), .config_status_n(config_status_n),
        .config_abort(config_abort), .reconfig_req(reconfig_req), .icr_data(icr_data),
        .icr_data_vld(icr_data_vld), .analyzer_ctrl(analyzer_ctrl)
    );

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic ir(input logic [9:0] c);
        u_scan_tester.scan(1, 10, {22'b0, c}, q);
        chk(q, 32'h1);
    endtask

    task automatic dr(input int n);
        d = $random(seed);
        u_scan_tester.scan(0, n, d, q);
    endtask

    // Pin drive expected for the instruction now in force
    task automatic pins(input logic [9:0] c);
        if (c == 10'h00B)
            chk(pin_oe, 0);
        else if (c == 10'h00A || c == 10'h000)
            chk({pin_out, pin_oe}, {bo, be});
        else
            chk({pin_out, pin_oe}, {core_out, core_oe});
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // Watchdog so a stuck run still reaches the verdict
    initial
    begin
        repeat (50000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial
    begin
        {checksum, user_code, analyzer_probe} = {$random(seed), $random(seed), $random(seed)};
        {pin_in, core_out, core_oe} = $random(seed);
        repeat (4) @(negedge clk);
        rst_b = 1;
        repeat (3) @(negedge clk);
        u_scan_tester.tlr();
        // Pll bits ride the chain only before configuration ends
        for (int k = 0; k < 2; k++)
        begin
            config_done = k;
            ir(10'h005);
            for (int i = 0; i < 8; i++)
                exp[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
            exp[31:24] = k ? 8'h00 : pll_m;
            dr(k ? 24 : 32);
            chk(q, exp);
            pll_m = k ? pll_m : d[31:24];
            bsr_m = d[23:0];
            chk(pll_reconfig, pll_m);
        end
        for (int i = 0; i < 8; i++)
            {be[i], bo[i]} = bsr_m[3*i+1 +: 2];
        ir(10'h000);
        pins(10'h000);
        // Word and bypass instructions, unlisted code included
        foreach (codes[j])
        begin
            usercode_checksum_sel = $random(seed);
            ir(codes[j]);
            dr(32);
            exp = {d[30:0], 1'b0};
            if (codes[j] == 10'h006)
                exp = {ID_V, ID_P, ID_M, 1'b1};
            if (codes[j] == 10'h007)
                exp = usercode_checksum_sel ? checksum : user_code;
            if (codes[j] == 10'h00E)
                exp = analyzer_probe;
            chk(q, exp);
            pins(codes[j]);
            if (codes[j] == 10'h00E)
                chk(analyzer_ctrl, d);
        end
        // Port-driven configuration; no boundary tests while busy
        config_busy = 1;
        ir(10'h00A);
        pins(10'h3FF);
        vlds = 0;
        ir(10'h002);
        dr(5);
        chk(vlds, 5);
        chk(icr_data, d[4]);
        aborts = 0;
        ir(10'h00D);
        chk(aborts, 1);
        config_busy = 0;
        dr(16);
        chk(q, 0);
        chk(io_std, d[15:0]);
        chk(config_status_n, 0);
        reqs = 0;
        ir(10'h001);
        chk(reqs, 1);
        chk(config_status_n, 1);
        ir(10'h00D);
        config_request_n = 0;
        #100 chk(config_status_n, 1);
        wrap_up();
    end
endmodule
